/* src/fqb_consts.vh */
`ifndef FQB_CONSTS_VH
`define FQB_CONSTS_VH

// Register byte offsets on the bus
`define FQB_OFS_CONTROL 12'h000
`define FQB_OFS_COND 12'h004
`define FQB_OFS_COUNT 12'h008
`define FQB_OFS_LINK 12'h00C
`define FQB_OFS_FETCH_PC 12'h010
`define FQB_OFS_STATUS 12'h014
`define FQB_OFS_MISPREDICT 12'h018

// Control register fields and reset values
`define FQB_CTL_FETCH_EN 0
`define FQB_RST_CONTROL 32'h0000_0000
`define FQB_RST_WORD 32'h0000_0000

// Status register fields
`define FQB_STS_QVALID_LO 0
`define FQB_STS_OUTSTANDING 3
`define FQB_STS_DISCARD 4
`define FQB_STS_SPEC_LO 8

// Instruction encoding fields
`define FQB_OP_UNCOND 6'h12
`define FQB_OP_COND 6'h10
`define FQB_OP_EXT 6'h13
`define FQB_XO_VIA_LINK 10'h010
`define FQB_XO_VIA_COUNT 10'h210

// Speculative fetch limits, in instructions
`define FQB_SPEC_LIMIT_CACHED 3'h5
`define FQB_SPEC_LIMIT_UNCACHED 3'h2

// Step from one instruction word to the next
`define FQB_WORD_STEP 32'h0000_0004

`endif

/* src/fqb_branch_eval.v */
`timescale 1ns/10ps
`include "fqb_consts.vh"

// Branch decode, target, outcome and static prediction for one queue slot
module fqb_branch_eval (
  input wire [31:0] instr,
  input wire [31:0] addr,
  input wire [31:0] condReg,
  input wire [31:0] countReg,
  input wire [31:0] linkReg,
  output wire isBranch,
  output wire taken,
  output wire predictTaken,
  output wire ctrDecrement,
  output wire [31:0] target,
  output wire [31:0] ctrNext
);
  wire [5:0] opcode = instr[31:26];
  wire [9:0] extOp = instr[10:1];
  wire isUncond = (opcode == `FQB_OP_UNCOND);
  wire isCondDisp = (opcode == `FQB_OP_COND);
  wire viaLink = (extOp == `FQB_XO_VIA_LINK);
  wire isCondReg = (opcode == `FQB_OP_EXT) && (viaLink || (extOp == `FQB_XO_VIA_COUNT));
  // Option bits, numbered here with bit 0 as the leftmost field bit
  wire crIgnore = instr[25];
  wire crValue = instr[24];
  wire ctrIgnore = instr[23];
  wire ctrZero = instr[22];
  wire reversePredict = instr[21];
  wire [4:0] bitSelect = instr[20:16];
  wire absFlag = instr[1];
  wire [31:0] longDisp;
  wire [31:0] shortDisp;
  wire [31:0] dispTarget;
  wire [31:0] regTarget;
  wire crBit;
  wire ctrOk;
  wire condOk;
  wire alwaysForm;
  wire signBit;

  assign longDisp = {{6{instr[25]}}, instr[25:2], 2'b00};
  assign shortDisp = {{16{instr[15]}}, instr[15:2], 2'b00};
  // absolute form adds zero, so negatives wrap high
  assign dispTarget = (absFlag ? `FQB_RST_WORD : addr) + (isUncond ? longDisp : shortDisp);
  // Register forms drop the two low bits of the target
  assign regTarget = viaLink ? {linkReg[31:2], 2'b00} : {countReg[31:2], 2'b00};
  assign target = isCondReg ? regTarget : dispTarget;

  // leftmost bit is bit 0, hence the inverted select
  assign crBit = condReg[~bitSelect];
  assign condOk = crIgnore | (crBit == crValue);
  assign ctrNext = countReg - `FQB_WORD_STEP / 32'h0000_0004;
  assign ctrOk = ctrIgnore | ((ctrNext == `FQB_RST_WORD) == ctrZero);
  assign ctrDecrement = (isCondDisp | isCondReg) & ~ctrIgnore;
  assign taken = isUncond | (ctrOk & condOk);
  assign isBranch = isUncond | isCondDisp | isCondReg;

  // default prediction from always-form or sign
  assign alwaysForm = crIgnore & ctrIgnore;
  assign signBit = isCondDisp & instr[15];
  assign predictTaken = isUncond | alwaysForm | (signBit ^ reversePredict);
endmodule // fqb_branch_eval

/* src/fqb_fetch_queue.v */
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "fqb_consts.vh"

module fqb_fetch_queue (
  input wire clk_sys,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire exuRequest,
  input wire exuTake,
  input wire condReady,
  output reg decodeValid,
  output reg [31:0] decodeInstr,
  output reg [31:0] decodeAddr,
  output reg fetchReq,
  output reg [31:0] fetchAddr,
  output reg [1:0] fetchMax,
  input wire icuValid,
  input wire icuTwo,
  input wire icuCacheable,
  input wire [31:0] icuData0,
  input wire [31:0] icuData1,
  output reg cacheWrite,
  output reg cacheWriteTwo,
  output reg [31:0] cacheWriteAddr,
  output reg [31:0] cacheWriteData0,
  output reg [31:0] cacheWriteData1,
  output reg branchMispredict
);
  // Slot 0 is decode, 1 near prefetch, 2 far prefetch
  reg [2:0] qValid;
  reg [2:0] qPredicted;
  reg [2:0] qPredTaken;
  reg [31:0] qInstr [0:2];
  reg [31:0] qAddr [0:2];
  reg [31:0] control;
  reg [31:0] condReg;
  reg [31:0] countReg;
  reg [31:0] linkReg;
  reg [31:0] fetchPc;
  reg [31:0] mispredictCount;
  reg outstanding;
  reg discardPending;
  reg pathCacheable;
  reg [2:0] specCount;
  reg [2:0] next_qValid;
  reg [2:0] next_qPredicted;
  reg [2:0] next_qPredTaken;
  reg [31:0] next_qInstr [0:2];
  reg [31:0] next_qAddr [0:2];
  reg [31:0] next_fetchPc;
  reg [1:0] placed;
  reg redirect;
  integer k;
  integer j;

  wire dBranch;
  wire dTaken;
  wire dPredict;
  wire dCtrDec;
  wire [31:0] dTarget;
  wire [31:0] dCtrNext;
  wire nBranch;
  wire nPredict;
  wire [31:0] nTarget;

  // decode slot evaluator resolves and predicts
  fqb_branch_eval decodeEval (
    .instr(qInstr[0]),
    .addr(qAddr[0]),
    .condReg(condReg),
    .countReg(countReg),
    .linkReg(linkReg),
    .isBranch(dBranch),
    .taken(dTaken),
    .predictTaken(dPredict),
    .ctrDecrement(dCtrDec),
    .target(dTarget),
    .ctrNext(dCtrNext)
  );

  fqb_branch_eval nearEval (
    .instr(qInstr[1]),
    .addr(qAddr[1]),
    .condReg(condReg),
    .countReg(countReg),
    .linkReg(linkReg),
    .isBranch(nBranch),
    .taken(),
    .predictTaken(nPredict),
    .ctrDecrement(),
    .target(nTarget),
    .ctrNext()
  );

  // Count of a small set of valid bits
  function [1:0] fqb_count3;
    input [2:0] v;
    begin
      fqb_count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    end
  endfunction

  // Bus phases; writes land only at the completing access edge
  wire setup = psel & ~penable;
  wire busWrite = psel & penable & pready & pwrite & ~pslverr;
  wire pcWrite = busWrite && (paddr == `FQB_OFS_FETCH_PC);

  // a branch leaves decode only once its inputs are ready
  wire consume = exuTake & qValid[0] & (~dBranch | condReady);
  wire resolveBranch = consume & dBranch;
  wire mispredict = resolveBranch & (dTaken != qPredTaken[0]);
  wire decodePredTaken = qValid[0] & dBranch & ~qPredicted[0] & ~consume & dPredict;
  wire nearPredTaken = qValid[1] & nBranch & ~qPredicted[1] & nPredict;
  wire specActive = qValid[0] & dBranch;
  wire [2:0] specLimit = pathCacheable ? `FQB_SPEC_LIMIT_CACHED : `FQB_SPEC_LIMIT_UNCACHED;
  wire [2:0] specRoom = specActive ? (specLimit - specCount) : 3'h2;
  wire [1:0] freeSlots = 2'h3 - fqb_count3(qValid);
  wire accept = icuValid & outstanding & ~discardPending & ~redirect & ~pcWrite;

  // Queue next state: mark predictions, flush, shift, then fill
  always @* begin
    next_qValid = qValid;
    next_qPredicted = qPredicted;
    next_qPredTaken = qPredTaken;
    next_fetchPc = fetchPc;
    redirect = 1'b0;
    placed = 2'h0;
    for (k = 0; k < 3; k = k + 1) begin
      next_qInstr[k] = qInstr[k];
      next_qAddr[k] = qAddr[k];
    end
    if (qValid[1] && nBranch && !qPredicted[1]) begin
      next_qPredicted[1] = 1'b1;
      next_qPredTaken[1] = nPredict;
    end
    if (qValid[0] && dBranch && !qPredicted[0]) begin
      next_qPredicted[0] = 1'b1;
      next_qPredTaken[0] = dPredict & ~consume;
    end
    if (mispredict) begin
      next_qValid = 3'h0;
      redirect = 1'b1;
      next_fetchPc = dTaken ? dTarget : qAddr[0] + `FQB_WORD_STEP;
    end else if (decodePredTaken) begin
      next_qValid[2:1] = 2'h0;
      redirect = 1'b1;
      next_fetchPc = dTarget;
    end else if (nearPredTaken) begin
      next_qValid[2] = 1'b0;
      redirect = 1'b1;
      next_fetchPc = nTarget;
    end
    if (pcWrite) begin
      next_qValid = 3'h0;
      next_fetchPc = {pwdata[31:2], 2'b00};
    end
    if (consume) begin
      next_qValid = {1'b0, next_qValid[2:1]};
      next_qPredicted = {1'b0, next_qPredicted[2:1]};
      next_qPredTaken = {1'b0, next_qPredTaken[2:1]};
      next_qInstr[0] = qInstr[1];
      next_qAddr[0] = qAddr[1];
      next_qInstr[1] = qInstr[2];
      next_qAddr[1] = qAddr[2];
    end
    // a pair into an empty queue lands in decode and near
    // far slot catches what a stalled decode cannot take
    if (accept) begin
      for (k = 0; k < 3; k = k + 1) begin
        if (!next_qValid[k] && placed < (icuTwo ? 2'h2 : 2'h1)) begin
          next_qValid[k] = 1'b1;
          next_qPredicted[k] = 1'b0;
          next_qPredTaken[k] = 1'b0;
          next_qInstr[k] = (placed == 2'h0) ? icuData0 : icuData1;
          next_qAddr[k] = (placed == 2'h0) ? fetchAddr : fetchAddr + `FQB_WORD_STEP;
          placed = placed + 2'h1;
        end
      end
      next_fetchPc = fetchAddr + (placed == 2'h2 ? 32'h0000_0008 : `FQB_WORD_STEP);
    end
  end

  // Queue slots and decode outputs
  always @(posedge clk_sys) begin
    if (reset) begin
      qValid <= 3'h0;
      qPredicted <= 3'h0;
      qPredTaken <= 3'h0;
      for (j = 0; j < 3; j = j + 1) begin
        qInstr[j] <= `FQB_RST_WORD;
        qAddr[j] <= `FQB_RST_WORD;
      end
      fetchPc <= `FQB_RST_WORD;
      decodeValid <= 1'b0;
      decodeInstr <= `FQB_RST_WORD;
      decodeAddr <= `FQB_RST_WORD;
    end else begin
      qValid <= next_qValid;
      qPredicted <= next_qPredicted;
      qPredTaken <= next_qPredTaken;
      for (j = 0; j < 3; j = j + 1) begin
        qInstr[j] <= next_qInstr[j];
        qAddr[j] <= next_qAddr[j];
      end
      fetchPc <= next_fetchPc;
      // decode slot mirrored for the execution unit's stages
      decodeValid <= next_qValid[0];
      decodeInstr <= next_qInstr[0];
      decodeAddr <= next_qAddr[0];
    end
  end

  // Fetch requests and speculation accounting
  always @(posedge clk_sys) begin
    if (reset) begin
      fetchReq <= 1'b0;
      fetchAddr <= `FQB_RST_WORD;
      fetchMax <= 2'h0;
      outstanding <= 1'b0;
      discardPending <= 1'b0;
      pathCacheable <= 1'b1;
      specCount <= 3'h0;
    end else begin
      fetchReq <= 1'b0;
      if (icuValid && outstanding) begin
        outstanding <= 1'b0;
        discardPending <= 1'b0;
        pathCacheable <= icuCacheable;
      end else if ((redirect || pcWrite) && outstanding) begin
        // In-flight answer belongs to the abandoned path
        discardPending <= 1'b1;
      end
      if (resolveBranch || pcWrite || mispredict) begin
        specCount <= 3'h0;
      end else if (accept && specActive) begin
        specCount <= specCount + {1'b0, placed};
      end
      // only on the execution unit's demand
      // no request when both prefetch slots are full
      if (control[`FQB_CTL_FETCH_EN] && exuRequest && !outstanding && !icuValid
          && !redirect && !pcWrite && freeSlots != 2'h0 && specRoom != 3'h0) begin
        fetchReq <= 1'b1;
        fetchAddr <= fetchPc;
        fetchMax <= (freeSlots == 2'h1 || specRoom == 3'h1) ? 2'h1 : 2'h2;
        outstanding <= 1'b1;
      end
    end
  end

  // Cache array fill, kept even for answers the queue drops
  always @(posedge clk_sys) begin
    if (reset) begin
      cacheWrite <= 1'b0;
      cacheWriteTwo <= 1'b0;
      cacheWriteAddr <= `FQB_RST_WORD;
      cacheWriteData0 <= `FQB_RST_WORD;
      cacheWriteData1 <= `FQB_RST_WORD;
    end else begin
      // only cacheable words reach the array
      cacheWrite <= icuValid & outstanding & icuCacheable;
      if (icuValid && outstanding) begin
        cacheWriteTwo <= icuTwo;
        cacheWriteAddr <= fetchAddr;
        cacheWriteData0 <= icuData0;
        cacheWriteData1 <= icuData1;
      end
    end
  end

  // Branch state registers and bus writes
  always @(posedge clk_sys) begin
    if (reset) begin
      control <= `FQB_RST_CONTROL;
      condReg <= `FQB_RST_WORD;
      countReg <= `FQB_RST_WORD;
      linkReg <= `FQB_RST_WORD;
      mispredictCount <= `FQB_RST_WORD;
      branchMispredict <= 1'b0;
    end else begin
      branchMispredict <= mispredict;
      if (mispredict) begin
        mispredictCount <= mispredictCount + 32'h0000_0001;
      end
      if (resolveBranch && dCtrDec) begin
        countReg <= dCtrNext;
      end
      // A bus write in the same cycle wins over the decrement
      if (busWrite) begin
        case (paddr)
          `FQB_OFS_CONTROL: control <= {31'h0000_0000, pwdata[`FQB_CTL_FETCH_EN]};
          `FQB_OFS_COND: condReg <= pwdata;
          `FQB_OFS_COUNT: countReg <= pwdata;
          `FQB_OFS_LINK: linkReg <= pwdata;
          `FQB_OFS_MISPREDICT: mispredictCount <= `FQB_RST_WORD;
          default: control <= control;
        endcase
      end
    end
  end

  // Bus answer prepared in setup, shown in the single access cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      prdata <= `FQB_RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= 1'b0;
        prdata <= `FQB_RST_WORD;
        case (paddr)
          `FQB_OFS_CONTROL: prdata <= control;
          `FQB_OFS_COND: prdata <= condReg;
          `FQB_OFS_COUNT: prdata <= countReg;
          `FQB_OFS_LINK: prdata <= linkReg;
          `FQB_OFS_FETCH_PC: prdata <= fetchPc;
          `FQB_OFS_STATUS: prdata <= {21'h00_0000, specCount, 3'h0, discardPending,
            outstanding, qValid};
          `FQB_OFS_MISPREDICT: prdata <= mispredictCount;
          default: pslverr <= 1'b1;
        endcase
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule // fqb_fetch_queue

/* tb/fqb_fetch_queue_sva.sv */
`timescale 1ns/10ps
// Port-level timing checks of the fetch queue
module fqb_fetch_queue_sva (
  input logic clk_sys,
  input logic reset,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic exuRequest,
  input logic exuTake,
  input logic decodeValid,
  input logic [31:0] decodeInstr,
  input logic [31:0] decodeAddr,
  input logic fetchReq,
  input logic [31:0] fetchAddr,
  input logic [1:0] fetchMax,
  input logic icuValid,
  input logic icuCacheable,
  input logic [31:0] icuData0,
  input logic cacheWrite,
  input logic [31:0] cacheWriteData0,
  input logic branchMispredict
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Flush step: queue empty, then the pulse is gone
  sequence s_flushPulse;
    !decodeValid ##1 !branchMispredict;
  endsequence
  // One outstanding request, so two quiet cycles follow
  sequence s_quietAfterReq;
    !fetchReq [*2];
  endsequence

  property p_apbAnswer;
    psel && !penable |=> pready;
  endproperty
  property p_errWithReady;
    pslverr |-> pready;
  endproperty
  property p_fetchOnRequest;
    fetchReq |-> $past(exuRequest) && (fetchMax == 2'b01 || fetchMax == 2'b10);
  endproperty
  property p_fetchSpacing;
    fetchReq |=> s_quietAfterReq;
  endproperty
  property p_fetchHold;
    !fetchReq |-> $stable(fetchAddr);
  endproperty
  property p_cacheFill;
    icuValid && icuCacheable |=> cacheWrite && cacheWriteData0 == $past(icuData0);
  endproperty
  property p_uncachedNoFill;
    icuValid && !icuCacheable |=> !cacheWrite;
  endproperty
  property p_emptyFill;
    icuValid && !decodeValid |=> !decodeValid ||
      (decodeInstr == $past(icuData0) && decodeAddr == $past(fetchAddr));
  endproperty
  property p_decodeHold;
    decodeValid && !exuTake && !psel |=> decodeValid && $stable(decodeAddr);
  endproperty
  property p_mispredictFlush;
    branchMispredict |-> s_flushPulse;
  endproperty

  a_apbAnswer: assert property (p_apbAnswer) else $error("pready late");
  a_errWithReady: assert property (p_errWithReady) else $error("pslverr without pready");
  a_fetchOnRequest: assert property (p_fetchOnRequest) // fetch on demand
    else $error("fetch without request");
  a_fetchSpacing: assert property (p_fetchSpacing) // single outstanding
    else $error("requests too close");
  a_fetchHold: assert property (p_fetchHold) else $error("fetchAddr moved");
  a_cacheFill: assert property (p_cacheFill) // cached fill
    else $error("cacheable word not written");
  a_uncachedNoFill: assert property (p_uncachedNoFill) // uncached skip
    else $error("uncacheable word written");
  a_emptyFill: assert property (p_emptyFill) // nearest slot
    else $error("first word not in decode");
  a_decodeHold: assert property (p_decodeHold) // held in decode
    else $error("decode slot lost");
  a_mispredictFlush: assert property (p_mispredictFlush) // flush
    else $error("queue not flushed");
endmodule // fqb_fetch_queue_sva

bind fqb_fetch_queue fqb_fetch_queue_sva chk (
  .clk_sys, .reset, .psel, .penable, .pready, .pslverr, .exuRequest, .exuTake,
  .decodeValid, .decodeInstr, .decodeAddr, .fetchReq, .fetchAddr, .fetchMax,
  .icuValid, .icuCacheable, .icuData0, .cacheWrite, .cacheWriteData0, .branchMispredict
);

/* tb/fqb_icu_model.sv */
`timescale 1ns/10ps
// Cache unit stand-in answering each request from a word table
module fqb_icu_model (
  input logic clk_sys,
  input logic reset,
  input logic fetchReq,
  input logic [31:0] fetchAddr,
  input logic [1:0] fetchMax,
  input logic [3:0] delay,
  input logic cacheable,
  output logic icuValid,
  output logic icuTwo,
  output logic icuCacheable,
  output logic [31:0] icuData0,
  output logic [31:0] icuData1
);
  logic [31:0] mem [0:63];
  logic [31:0] reqAddr;
  logic [1:0] reqMax;
  logic [3:0] waitCnt;
  logic busy;

  // Plain words carry their own address, so misplacement shows up
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'h6000_0000 | (i << 2);
    {icuValid, icuTwo, icuCacheable, busy} = 4'h0;
    icuData0 = 32'h0000_0000;
    icuData1 = 32'h0000_0000;
  end

  // Data lines toggle when idle so stale words never look valid
  always @(posedge clk_sys) begin
    icuValid <= 1'b0;
    icuData0 <= ~icuData0;
    icuData1 <= ~icuData1;
    if (reset) begin
      busy <= 1'b0;
    end else if (fetchReq) begin
      busy <= 1'b1;
      reqAddr <= fetchAddr;
      reqMax <= fetchMax;
      waitCnt <= delay;
    end else if (busy && waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      icuValid <= 1'b1;
      icuTwo <= (reqMax == 2'b10);
      icuCacheable <= cacheable;
      icuData0 <= mem[reqAddr[7:2]];
      icuData1 <= mem[reqAddr[7:2] + 6'h01];
    end
  end
endmodule // fqb_icu_model

/* tb/tb_fetch_queue_branch_unit.sv */
`timescale 1ns/10ps
`define CHK(n, got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", n, exp, got); \
  end \
end

// Register calls and instruction consumption against hand-worked values
module tb_fetch_queue_branch_unit;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic exuRequest = 1'b0;
  logic exuTake = 1'b0;
  logic condReady = 1'b1;
  logic [3:0] delay = 4'h0;
  logic cacheable = 1'b1;
  logic [31:0] prdata, decodeInstr, decodeAddr, fetchAddr, icuData0, icuData1;
  logic pready, pslverr, decodeValid, fetchReq, icuValid, icuTwo, icuCacheable;
  logic [1:0] fetchMax;
  logic [4:0] opt;
  logic crv, taken, mis;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] seqA [6] = '{32'h0000_0100, 32'h0000_0104, 32'h0000_0108,
    32'h0000_0118, 32'hFFFF_FFFC, 32'h0000_0000};
  logic [31:0] seqB [5] = '{32'h0000_0140, 32'h0000_0144, 32'h0000_0140,
    32'h0000_0144, 32'h0000_0148};
  logic [5:0] cases [8] = '{6'h08, 6'h09, 6'h19, 6'h0A, 6'h28, 6'h00, 6'h04, 6'h25};

  fqb_fetch_queue dut (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .exuRequest, .exuTake, .condReady, .decodeValid, .decodeInstr,
    .decodeAddr, .fetchReq, .fetchAddr, .fetchMax, .icuValid, .icuTwo, .icuCacheable,
    .icuData0, .icuData1, .cacheWrite(), .cacheWriteTwo(), .cacheWriteAddr(),
    .cacheWriteData0(), .cacheWriteData1(), .branchMispredict()
  );
  fqb_icu_model icu (
    .clk_sys, .reset, .fetchReq, .fetchAddr, .fetchMax, .delay, .cacheable,
    .icuValid, .icuTwo, .icuCacheable, .icuData0, .icuData1
  );

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  function automatic logic [31:0] br_long(input logic [31:0] d, input logic aa);
    return {6'h12, d[25:2], aa, 1'b0};
  endfunction
  function automatic logic [31:0] br_cond(input logic [4:0] o, input logic [31:0] d);
    return {6'h10, o, 5'h05, d[15:2], 2'b00};
  endfunction

  // One bus transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    // Answer taken at the very edge that sees pready high
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK("pslverr", e, expErr)
    if (!expErr) `CHK("prdata", q, exp)
  endtask
  // Wait for a decoded word, compare it, then consume it
  task automatic take(input logic [31:0] a);
    int i;
    i = 0;
    @(negedge clk_sys);
    while (decodeValid !== 1'b1 && i < 200) begin
      @(negedge clk_sys);
      i++;
    end
    if (decodeValid !== 1'b1) n_fail++;
    `CHK("decodeAddr", decodeAddr, a)
    `CHK("decodeInstr", decodeInstr, icu.mem[a[7:2]])
    @(posedge clk_sys) exuTake <= 1'b1;
    @(posedge clk_sys) exuTake <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end

  // Main sequence
  initial begin
    icu.mem[2] = br_long(32'h0000_0010, 1'b0);
    icu.mem[6] = br_long(32'hFFFF_FFFC, 1'b1);
    icu.mem[17] = br_cond(5'h10, 32'hFFFF_FFFC);
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rd(12'h000, 32'h0000_0000, 1'b0);
    rd(12'h0FC, 32'h0000_0000, 1'b1);
    wr(12'h008, 32'h0000_0005);
    rd(12'h008, 32'h0000_0005, 1'b0);
    wr(12'h000, 32'h0000_0001);
    repeat (10) @(posedge clk_sys);
    rd(12'h014, 32'h0000_0000, 1'b0); // idle without request
    $display("test idle done");
    exuRequest <= 1'b1;
    wr(12'h010, 32'h0000_0100);
    foreach (seqA[i]) take(seqA[i]); // long branches
    rd(12'h018, 32'h0000_0000, 1'b0); // no wrong guesses
    $display("test long branches done");
    // Slow uncached counted loop; the exit is guessed wrong
    delay <= 4'h3;
    cacheable <= 1'b0;
    wr(12'h008, 32'h0000_0002);
    wr(12'h010, 32'h0000_0140);
    foreach (seqB[i]) take(seqB[i]); // loop path
    rd(12'h008, 32'h0000_0000, 1'b0); // counter written back
    rd(12'h018, 32'h0000_0001, 1'b0); // one wrong guess
    $display("test counted loop done");
    // Option field table, forward displacement so the default guess is not taken
    delay <= 4'h1;
    cacheable <= 1'b1;
    foreach (cases[k]) begin
      opt = cases[k][5:1];
      crv = cases[k][0];
      taken = (opt[4] | (crv == opt[3])) & (opt[2] | opt[1]);
      mis = ((opt[4] & opt[2]) | opt[0]) != taken;
      icu.mem[33] = br_cond(opt, 32'h0000_0008);
      wr(12'h004, crv ? 32'h0400_0000 : 32'h0000_0000);
      wr(12'h008, 32'h0000_0001);
      wr(12'h018, 32'h0000_0000);
      wr(12'h010, 32'h0000_0180);
      take(32'h0000_0180);
      take(32'h0000_0184); // branch decode
      take(taken ? 32'h0000_018C : 32'h0000_0188); // outcome
      rd(12'h008, {31'h0, opt[2]}, 1'b0); // counter value
      rd(12'h018, {31'h0, mis}, 1'b0); // guess
    end
    $display("test option table done");
    end_of_test;
  end
endmodule // tb_fetch_queue_branch_unit
